// *** design/fsl_loader.sv ***
// fuse array controller: program, load, setting table parser and self-check
// Operation
// - head with upper nibble A is followed by address MSB, LSB, then data
// - head with upper nibble 5 continues at address after previous record
// - head low nibble is data count minus one
// - any other head upper nibble ends the setting table
// - table accepted only if first byte equals the marker
// - data bytes go to consecutive register addresses
// - power-up data enable starts a load on first streaming; the setting table follows only if power-up setting is also set
// - load option bit 4 enables self-check during data load
// - self-check compares with zero or with the buffer byte
// - done and error flags plus first error address read back
// - program control bit 7 reads busy; bit 0 triggers programming
// - load control bit 7 reads busy; bit 0 is the load trigger
// - mode bit 7 inhibits programming; bit 6 selects manual range
// - option bits 2, 1, 0 enable power-up data, power-up setting, write setting
// - manual start and end addresses are 16-bit pairs resetting to zero
// - setting table start is a 16-bit pair
// - separate 8-bit strobe gaps for programming and loading
// - writing one to load control loads whole array or manual range
// - setting bytes are stored in the buffer while being interpreted
`timescale 1ns/1ns
module fsl_loader #(
    parameter int BUF_DEPTH  = 1536,
    parameter int FUSE_DEPTH = 1024
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        stream_on_in,
    output logic      [$clog2(BUF_DEPTH)-1:0] fuse_addr_out,
    output logic             fuse_rd_strobe_out,
    input  wire logic [7:0]  fuse_rdata_in,
    output logic             fuse_pgm_strobe_out,
    output logic      [7:0]  fuse_wdata_out,
    output logic             cfg_wr_out,
    output logic      [15:0] cfg_addr_out,
    output logic      [7:0]  cfg_data_out
);
    localparam int IW = $clog2(BUF_DEPTH);
    localparam logic [IW-1:0] FUSE_LAST = IW'(FUSE_DEPTH - 1);

    // register address match
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    // buffer index of a buffer-window address
    function automatic logic [IW-1:0] buf_idx(input logic [15:0] a);
        logic [15:0] d;
        d = a - fsl_pkg::BUF_BASE;
        buf_idx = d[IW-1:0];
    endfunction

    logic [7:0]  mode_reg, opt_reg, pgap_reg, lgap_reg;
    logic [15:0] mstart_reg, mend_reg, sstart_reg, err_addr_reg;
    logic        load_en_reg, pgm_req_reg, pu_req_reg, pu_seen_reg;
    logic        chk_done_reg, chk_err_reg, chk_act_reg;
    logic        job_set_reg, set_pend_reg;
    logic [7:0]  buf_mem [BUF_DEPTH];
    logic [IW-1:0] idx_reg, end_reg;
    logic [7:0]  gap_reg;
    logic [3:0]  cnt_reg;
    logic [15:0] waddr_reg;
    fsl_pkg::fsl_seq_t   state_reg, state_next;
    fsl_pkg::fsl_parse_t pst_reg;

    logic        buf_hit, load_wr, pgm_wr, idle;
    logic        set_stop, take_last, start_pgm, start_load, start_pu;
    logic        mismatch;
    logic [7:0]  expect_byte;

    // request decode
    always_comb begin
        buf_hit   = (reg_addr_in >= fsl_pkg::BUF_BASE) &&
                    (reg_addr_in <  fsl_pkg::BUF_BASE + 16'(BUF_DEPTH));
        load_wr   = reg_wr_in && hit(reg_addr_in, fsl_pkg::REG_LOAD_CTRL) && reg_wdata_in[fsl_pkg::BIT_TRIG];
        pgm_wr    = reg_wr_in && hit(reg_addr_in, fsl_pkg::REG_PGM_CTRL) && reg_wdata_in[fsl_pkg::BIT_TRIG];
        idle      = (state_reg == fsl_pkg::S_IDLE);
        start_pgm  = idle && pgm_req_reg && !mode_reg[fsl_pkg::BIT_PGM_DIS];
        start_load = idle && !start_pgm && load_en_reg;
        start_pu   = idle && !start_pgm && !load_en_reg && pu_req_reg;
    end

    // parser stop and end-of-job decode
    always_comb begin
        set_stop = ((pst_reg == fsl_pkg::P_MARK) && (fuse_rdata_in != fsl_pkg::TABLE_MARKER)) ||
                   ((pst_reg == fsl_pkg::P_HEAD) &&
                    (fuse_rdata_in[7:4] != fsl_pkg::ADDRESSED_RECORD_HEAD) &&
                    (fuse_rdata_in[7:4] != fsl_pkg::CONTINUED_RECORD_HEAD));
        take_last = job_set_reg ? (set_stop || idx_reg == FUSE_LAST) : (idx_reg == end_reg);
        expect_byte = opt_reg[fsl_pkg::BIT_CHK_SEL] ? 8'h00 : buf_mem[idx_reg];
        mismatch = (fuse_rdata_in != expect_byte);
    end

    // control registers written by the host
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_reg   <= fsl_pkg::MODE_RST;
            opt_reg    <= fsl_pkg::OPT_RST;
            mstart_reg <= {fsl_pkg::ADDR_RST, fsl_pkg::ADDR_RST};
            mend_reg   <= {fsl_pkg::ADDR_RST, fsl_pkg::ADDR_RST};
            sstart_reg <= {fsl_pkg::ADDR_RST, fsl_pkg::ADDR_RST};
            pgap_reg   <= fsl_pkg::PGM_GAP_RST;
            lgap_reg   <= fsl_pkg::LOAD_GAP_RST;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, fsl_pkg::REG_MODE_CTRL))  mode_reg <= reg_wdata_in;
            if (hit(reg_addr_in, fsl_pkg::REG_LOAD_OPT))   opt_reg <= reg_wdata_in;
            if (hit(reg_addr_in, fsl_pkg::REG_MSTART_HI))  mstart_reg[15:8] <= reg_wdata_in;
            if (hit(reg_addr_in, fsl_pkg::REG_MSTART_LO))  mstart_reg[7:0] <= reg_wdata_in;
            if (hit(reg_addr_in, fsl_pkg::REG_MEND_HI))    mend_reg[15:8] <= reg_wdata_in;
            if (hit(reg_addr_in, fsl_pkg::REG_MEND_LO))    mend_reg[7:0] <= reg_wdata_in;
            if (hit(reg_addr_in, fsl_pkg::REG_SSTART_HI))  sstart_reg[15:8] <= reg_wdata_in;
            if (hit(reg_addr_in, fsl_pkg::REG_SSTART_LO))  sstart_reg[7:0] <= reg_wdata_in;
            if (hit(reg_addr_in, fsl_pkg::REG_PGM_GAP))    pgap_reg <= reg_wdata_in;
            if (hit(reg_addr_in, fsl_pkg::REG_LOAD_GAP))   lgap_reg <= reg_wdata_in;
        end
    end

    // job requests; a new request beats the clear of the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            load_en_reg <= 1'b0;
            pgm_req_reg <= 1'b0;
            pu_req_reg  <= 1'b0;
            pu_seen_reg <= 1'b0;
        end else begin
            if (state_reg == fsl_pkg::S_TAKE && take_last && !job_set_reg && !set_pend_reg)
                load_en_reg <= 1'b0;
            if (state_reg == fsl_pkg::S_TAKE && take_last && job_set_reg)
                load_en_reg <= 1'b0;
            if (load_wr)
                load_en_reg <= 1'b1;
            if (start_pgm)
                pgm_req_reg <= 1'b0;
            if (pgm_wr && !mode_reg[fsl_pkg::BIT_PGM_DIS])
                pgm_req_reg <= 1'b1;
            if (start_pu)
                pu_req_reg <= 1'b0;
            if (stream_on_in && !pu_seen_reg) begin
                pu_seen_reg <= 1'b1;
                pu_req_reg  <= opt_reg[fsl_pkg::BIT_PU_DATA];
            end
        end
    end

    // sequencer state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            state_reg <= fsl_pkg::S_IDLE;
        else
            state_reg <= state_next;
    end

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fsl_pkg::S_IDLE: begin
                if (start_pgm)
                    state_next = fsl_pkg::S_PSTROBE;
                else if (start_load || start_pu)
                    state_next = fsl_pkg::S_STROBE;
            end
            fsl_pkg::S_STROBE:  state_next = fsl_pkg::S_GAP;
            fsl_pkg::S_GAP:     if (gap_reg == 8'h00) state_next = fsl_pkg::S_TAKE;
            fsl_pkg::S_TAKE: begin
                if (take_last && (job_set_reg || !set_pend_reg))
                    state_next = fsl_pkg::S_IDLE;
                else
                    state_next = fsl_pkg::S_STROBE;
            end
            fsl_pkg::S_PSTROBE: state_next = fsl_pkg::S_PGAP;
            fsl_pkg::S_PGAP: begin
                if (gap_reg == 8'h00)
                    state_next = (idx_reg == end_reg) ? fsl_pkg::S_IDLE : fsl_pkg::S_PSTROBE;
            end
            default:            state_next = fsl_pkg::S_IDLE;
        endcase
    end

    // job set-up, address walk and strobe gaps
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idx_reg      <= '0;
            end_reg      <= '0;
            gap_reg      <= 8'h00;
            job_set_reg  <= 1'b0;
            set_pend_reg <= 1'b0;
        end else begin
            case (state_reg)
                fsl_pkg::S_IDLE: begin
                    job_set_reg <= 1'b0;
                    if (start_pgm) begin
                        idx_reg <= buf_idx(mstart_reg);
                        end_reg <= buf_idx(mend_reg);
                    end else if (start_load || start_pu) begin
                        // auto range copies the whole array
                        idx_reg <= mode_reg[fsl_pkg::BIT_MANUAL] ? buf_idx(mstart_reg) : '0;
                        end_reg <= mode_reg[fsl_pkg::BIT_MANUAL] ? buf_idx(mend_reg) : FUSE_LAST;
                        set_pend_reg <= start_load ? opt_reg[fsl_pkg::BIT_WR_SET] :
                                        opt_reg[fsl_pkg::BIT_PU_SET];
                    end
                end
                fsl_pkg::S_STROBE:  gap_reg <= lgap_reg;
                fsl_pkg::S_PSTROBE: gap_reg <= pgap_reg;
                fsl_pkg::S_GAP:     gap_reg <= gap_reg - 8'h01;
                fsl_pkg::S_PGAP: begin
                    gap_reg <= gap_reg - 8'h01;
                    if (gap_reg == 8'h00)
                        idx_reg <= idx_reg + IW'(1);
                end
                fsl_pkg::S_TAKE: begin
                    if (take_last && !job_set_reg && set_pend_reg) begin
                        // data load done, setting table follows
                        job_set_reg  <= 1'b1;
                        set_pend_reg <= 1'b0;
                        idx_reg      <= sstart_reg[IW-1:0];
                    end else begin
                        idx_reg <= idx_reg + IW'(1);
                    end
                end
                default: gap_reg <= 8'h00;
            endcase
        end
    end

    // setting table parser
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pst_reg      <= fsl_pkg::P_MARK;
            cnt_reg      <= 4'h0;
            waddr_reg    <= 16'h0000;
            cfg_wr_out   <= 1'b0;
            cfg_addr_out <= 16'h0000;
            cfg_data_out <= 8'h00;
        end else begin
            cfg_wr_out <= 1'b0;
            if (!job_set_reg)
                pst_reg <= fsl_pkg::P_MARK;
            else if (state_reg == fsl_pkg::S_TAKE) begin
                case (pst_reg)
                    fsl_pkg::P_MARK: pst_reg <= fsl_pkg::P_HEAD;
                    fsl_pkg::P_HEAD: begin
                        cnt_reg <= fuse_rdata_in[3:0];
                        if (fuse_rdata_in[7:4] == fsl_pkg::ADDRESSED_RECORD_HEAD)
                            pst_reg <= fsl_pkg::P_AHI;
                        else
                            pst_reg <= fsl_pkg::P_DATA;
                    end
                    fsl_pkg::P_AHI: begin
                        waddr_reg[15:8] <= fuse_rdata_in;
                        pst_reg <= fsl_pkg::P_ALO;
                    end
                    fsl_pkg::P_ALO: begin
                        waddr_reg[7:0] <= fuse_rdata_in;
                        pst_reg <= fsl_pkg::P_DATA;
                    end
                    fsl_pkg::P_DATA: begin
                        cfg_wr_out   <= 1'b1;
                        cfg_addr_out <= waddr_reg;
                        cfg_data_out <= fuse_rdata_in;
                        waddr_reg    <= waddr_reg + 16'h0001;
                        cnt_reg      <= cnt_reg - 4'h1;
                        if (cnt_reg == 4'h0)
                            pst_reg <= fsl_pkg::P_HEAD;
                    end
                    default: pst_reg <= fsl_pkg::P_MARK;
                endcase
            end
        end
    end

    // self-check flags and first error address
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chk_act_reg  <= 1'b0;
            chk_done_reg <= 1'b0;
            chk_err_reg  <= 1'b0;
            err_addr_reg <= 16'h0000;
        end else if ((start_load || start_pu) && opt_reg[fsl_pkg::BIT_CHK_EN]) begin
            chk_act_reg  <= 1'b1;
            chk_done_reg <= 1'b0;
            chk_err_reg  <= 1'b0;
            err_addr_reg <= 16'h0000;
        end else if (state_reg == fsl_pkg::S_TAKE && !job_set_reg && chk_act_reg) begin
            if (mismatch && !chk_err_reg) begin
                chk_err_reg  <= 1'b1;
                err_addr_reg <= fsl_pkg::BUF_BASE + 16'(idx_reg);
            end
            if (take_last) begin
                chk_done_reg <= 1'b1;
                chk_act_reg  <= 1'b0;
            end
        end
    end

    // byte buffer; fuse reads win over host writes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < BUF_DEPTH; i++)
                buf_mem[i] <= 8'h00;
        end else begin
            if (reg_wr_in && buf_hit)
                buf_mem[buf_idx(reg_addr_in)] <= reg_wdata_in;
            if (state_reg == fsl_pkg::S_TAKE)
                buf_mem[idx_reg] <= fuse_rdata_in;
        end
    end

    // fuse array port
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            fuse_wdata_out <= 8'h00;
        else if (state_next == fsl_pkg::S_PSTROBE)
            fuse_wdata_out <= buf_mem[(state_reg == fsl_pkg::S_IDLE) ? buf_idx(mstart_reg) : idx_reg + IW'(1)];
    end
    assign fuse_addr_out       = idx_reg;
    assign fuse_rd_strobe_out  = (state_reg == fsl_pkg::S_STROBE);
    assign fuse_pgm_strobe_out = (state_reg == fsl_pkg::S_PSTROBE);

    // register read back, one cycle after the read strobe
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in) begin
            reg_rdata_out <= 8'h00;
            if (buf_hit)
                reg_rdata_out <= buf_mem[buf_idx(reg_addr_in)];
            if (hit(reg_addr_in, fsl_pkg::REG_PGM_CTRL))
                reg_rdata_out[fsl_pkg::BIT_BUSY] <= (state_reg == fsl_pkg::S_PSTROBE) ||
                                                    (state_reg == fsl_pkg::S_PGAP);
            if (hit(reg_addr_in, fsl_pkg::REG_LOAD_CTRL)) begin
                reg_rdata_out[fsl_pkg::BIT_BUSY]     <= !idle && !fuse_pgm_strobe_out &&
                                                        (state_reg != fsl_pkg::S_PGAP);
                reg_rdata_out[fsl_pkg::BIT_CHK_ERR]  <= chk_err_reg;
                reg_rdata_out[fsl_pkg::BIT_CHK_DONE] <= chk_done_reg;
                reg_rdata_out[fsl_pkg::BIT_TRIG]     <= load_en_reg;
            end
            if (hit(reg_addr_in, fsl_pkg::REG_MODE_CTRL)) reg_rdata_out <= mode_reg;
            if (hit(reg_addr_in, fsl_pkg::REG_LOAD_OPT))  reg_rdata_out <= opt_reg;
            if (hit(reg_addr_in, fsl_pkg::REG_MSTART_HI)) reg_rdata_out <= mstart_reg[15:8];
            if (hit(reg_addr_in, fsl_pkg::REG_MSTART_LO)) reg_rdata_out <= mstart_reg[7:0];
            if (hit(reg_addr_in, fsl_pkg::REG_MEND_HI))   reg_rdata_out <= mend_reg[15:8];
            if (hit(reg_addr_in, fsl_pkg::REG_MEND_LO))   reg_rdata_out <= mend_reg[7:0];
            if (hit(reg_addr_in, fsl_pkg::REG_SSTART_HI)) reg_rdata_out <= sstart_reg[15:8];
            if (hit(reg_addr_in, fsl_pkg::REG_SSTART_LO)) reg_rdata_out <= sstart_reg[7:0];
            if (hit(reg_addr_in, fsl_pkg::REG_ERRADR_HI)) reg_rdata_out <= err_addr_reg[15:8];
            if (hit(reg_addr_in, fsl_pkg::REG_ERRADR_LO)) reg_rdata_out <= err_addr_reg[7:0];
            if (hit(reg_addr_in, fsl_pkg::REG_PGM_GAP))   reg_rdata_out <= pgap_reg;
            if (hit(reg_addr_in, fsl_pkg::REG_LOAD_GAP))  reg_rdata_out <= lgap_reg;
        end
    end

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic take_set;
    assign take_set = (state_reg == fsl_pkg::S_TAKE) && job_set_reg;

    property p_marker;
        take_set && pst_reg == fsl_pkg::P_MARK && fuse_rdata_in != fsl_pkg::TABLE_MARKER
            |=> idle && !cfg_wr_out;
    endproperty
    a_marker: assert property (p_marker) else $error("bad marker did not stop parser");

    property p_addressed;
        take_set && pst_reg == fsl_pkg::P_HEAD && fuse_rdata_in[7:4] == fsl_pkg::ADDRESSED_RECORD_HEAD
            |=> pst_reg == fsl_pkg::P_AHI && cnt_reg == $past(fuse_rdata_in[3:0]);
    endproperty
    a_addressed: assert property (p_addressed) else $error("addressed head mis-parsed");

    property p_continued;
        take_set && pst_reg == fsl_pkg::P_HEAD && fuse_rdata_in[7:4] == fsl_pkg::CONTINUED_RECORD_HEAD
            |=> pst_reg == fsl_pkg::P_DATA && $stable(waddr_reg);
    endproperty
    a_continued: assert property (p_continued) else $error("continued head mis-parsed");

    property p_end_head;
        take_set && pst_reg == fsl_pkg::P_HEAD && set_stop |=> idle;
    endproperty
    a_end_head: assert property (p_end_head) else $error("end head did not stop parser");

    property p_consecutive;
        take_set && pst_reg == fsl_pkg::P_DATA
            |=> cfg_wr_out && cfg_addr_out == $past(waddr_reg) && waddr_reg == cfg_addr_out + 16'h0001;
    endproperty
    a_consecutive: assert property (p_consecutive) else $error("setting write address wrong");

    property p_inhibit;
        idle && mode_reg[fsl_pkg::BIT_PGM_DIS] |=> !fuse_pgm_strobe_out;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("programming while inhibited");

    property p_chk_done;
        state_reg == fsl_pkg::S_TAKE && !job_set_reg && chk_act_reg && take_last
            |=> chk_done_reg ##1 (chk_done_reg || chk_act_reg); // only a new checked load may clear it
    endproperty
    a_chk_done: assert property (p_chk_done) else $error("check done flag missing");

    property p_chk_clear;
        (start_load || start_pu) && opt_reg[fsl_pkg::BIT_CHK_EN] |=> !chk_done_reg && !chk_err_reg;
    endproperty
    a_chk_clear: assert property (p_chk_clear) else $error("check flags not cleared");

    property p_array_end;
        take_set && idx_reg == FUSE_LAST |=> idle;
    endproperty
    a_array_end: assert property (p_array_end) else $error("parser ran past array end");

    c_program: cover property (fuse_pgm_strobe_out ##[1:300] idle);
    c_setting: cover property (cfg_wr_out ##1 cfg_wr_out);
    c_chk_err: cover property ($rose(chk_err_reg));
endmodule // fsl_loader

// *** design/fsl_pkg.sv ***
// constants and types shared by the fuse setting loader
package fsl_pkg;
    // register offsets on the control bus
    localparam logic [15:0] REG_PGM_CTRL   = 16'h3d80;
    localparam logic [15:0] REG_LOAD_CTRL  = 16'h3d81;
    localparam logic [15:0] REG_MODE_CTRL  = 16'h3d84;
    localparam logic [15:0] REG_LOAD_OPT   = 16'h3d85;
    localparam logic [15:0] REG_MSTART_HI  = 16'h3d88;
    localparam logic [15:0] REG_MSTART_LO  = 16'h3d89;
    localparam logic [15:0] REG_MEND_HI    = 16'h3d8a;
    localparam logic [15:0] REG_MEND_LO    = 16'h3d8b;
    localparam logic [15:0] REG_SSTART_HI  = 16'h3d8c;
    localparam logic [15:0] REG_SSTART_LO  = 16'h3d8d;
    localparam logic [15:0] REG_ERRADR_HI  = 16'h3d8e;
    localparam logic [15:0] REG_ERRADR_LO  = 16'h3d8f;
    localparam logic [15:0] REG_PGM_GAP    = 16'h3d90;
    localparam logic [15:0] REG_LOAD_GAP   = 16'h3d91;
    localparam logic [15:0] BUF_BASE       = 16'h7000;
    // bit positions
    localparam int BIT_BUSY     = 7;
    localparam int BIT_TRIG     = 0;
    localparam int BIT_CHK_ERR  = 5;
    localparam int BIT_CHK_DONE = 4;
    localparam int BIT_PGM_DIS  = 7;
    localparam int BIT_MANUAL   = 6;
    localparam int BIT_CHK_SEL  = 5;
    localparam int BIT_CHK_EN   = 4;
    localparam int BIT_PU_DATA  = 2;
    localparam int BIT_PU_SET   = 1;
    localparam int BIT_WR_SET   = 0;
    // reset values
    localparam logic [7:0] MODE_RST     = 8'h00;
    localparam logic [7:0] OPT_RST      = 8'h13;
    localparam logic [7:0] ADDR_RST     = 8'h00;
    localparam logic [7:0] PGM_GAP_RST  = 8'h12;
    localparam logic [7:0] LOAD_GAP_RST = 8'h06;
    // setting table coding
    localparam logic [7:0] TABLE_MARKER          = 8'hdd;
    localparam logic [3:0] ADDRESSED_RECORD_HEAD = 4'ha;
    localparam logic [3:0] CONTINUED_RECORD_HEAD = 4'h5;
    // sequencer states, gray from idle through strobe and gap to take, and between program strobe and gap
    typedef enum logic [2:0] {
        S_IDLE    = 3'b000,
        S_STROBE  = 3'b001,
        S_GAP     = 3'b011,
        S_TAKE    = 3'b010,
        S_PSTROBE = 3'b110,
        S_PGAP    = 3'b111
    } fsl_seq_t;
    // setting parser states
    typedef enum logic [2:0] {
        P_MARK = 3'b000,
        P_HEAD = 3'b001,
        P_AHI  = 3'b011,
        P_ALO  = 3'b010,
        P_DATA = 3'b110
    } fsl_parse_t;
endpackage

// *** verif/fsl_fuse_model.sv ***
// behavioural fuse array on the far side of the loader
`timescale 1ns/1ns
module fsl_fuse_model #(
    parameter int DEPTH = 32,
    parameter int AW    = 6
) (
    input  wire logic          clk_in,
    input  wire logic [AW-1:0] fuse_addr_in,
    input  wire logic          fuse_rd_strobe_in,
    input  wire logic          fuse_pgm_strobe_in,
    input  wire logic [7:0]    fuse_wdata_in,
    output logic      [7:0]    fuse_rdata_out
);
    logic [7:0] mem [DEPTH];
    // blank fuses read zero; burning can only set bits
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        fuse_rdata_out = 8'h00;
    end
    always @(posedge clk_in) begin
        if (fuse_rd_strobe_in) fuse_rdata_out <= mem[fuse_addr_in];
        if (fuse_pgm_strobe_in) mem[fuse_addr_in] <= mem[fuse_addr_in] | fuse_wdata_in;
    end
endmodule // fsl_fuse_model

// *** verif/otp_setting_loader_bist_bench.sv ***
// register-level bench for the fuse setting loader
`timescale 1ns/1ns
module otp_setting_loader_bist_bench;
    logic clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, stream_on_in = 0;
    logic [15:0] reg_addr_in = 16'h0000, cfg_addr_out;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, fuse_rdata_in, fuse_wdata_out, cfg_data_out, d;
    logic [5:0] fuse_addr_out;
    logic fuse_rd_strobe_out, fuse_pgm_strobe_out, cfg_wr_out;
    logic [23:0] seen [$];
    logic [7:0] tbl [13] = '{8'hdd, 8'ha3, 8'h30, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h53, 8'h55, 8'h66, 8'h77, 8'h88};
    int miscompares = 0, samples_checked = 0;
    always #10 clk_in = ~clk_in;
    fsl_loader #(.BUF_DEPTH(64), .FUSE_DEPTH(32)) u_fsl_loader (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .stream_on_in(stream_on_in), .fuse_addr_out(fuse_addr_out),
        .fuse_rd_strobe_out(fuse_rd_strobe_out), .fuse_rdata_in(fuse_rdata_in),
        .fuse_pgm_strobe_out(fuse_pgm_strobe_out), .fuse_wdata_out(fuse_wdata_out), .cfg_wr_out(cfg_wr_out),
        .cfg_addr_out(cfg_addr_out), .cfg_data_out(cfg_data_out));
    fsl_fuse_model u_fsl_fuse_model (.clk_in(clk_in), .fuse_addr_in(fuse_addr_out),
        .fuse_rd_strobe_in(fuse_rd_strobe_out), .fuse_pgm_strobe_in(fuse_pgm_strobe_out),
        .fuse_wdata_in(fuse_wdata_out), .fuse_rdata_out(fuse_rdata_in));
    // collect register writes made by the setting parser
    always @(posedge clk_in) if (cfg_wr_out === 1'b1) seen.push_back({cfg_addr_out, cfg_data_out});
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk_in); reg_addr_in = a; reg_wdata_in = v; reg_wr_in = 1'b1;
        @(negedge clk_in); reg_wr_in = 1'b0;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk_in); reg_addr_in = a; reg_rd_in = 1'b1;
        @(negedge clk_in); reg_rd_in = 1'b0; chk({16'h0000, reg_rdata_out}, {16'h0000, exp});
    endtask
    // poll a busy or trigger bit until it drops, bounded
    task automatic wait_low(input logic [15:0] a, input int b);
        for (int n = 0; n < 500; n++) begin
            @(negedge clk_in); reg_addr_in = a; reg_rd_in = 1'b1;
            @(negedge clk_in); reg_rd_in = 1'b0;
            if (reg_rdata_out[b] === 1'b0) return;
        end
        miscompares++;
        $display("unexpected at %0t: got %h expected %h", $time, reg_rdata_out[b], 1'b0);
    endtask
    task automatic end_of_test;
        $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        end_of_test;
    end
    initial begin
        // preload after time zero so the blank-fuse start-up of the model cannot wipe it
        repeat (8) @(negedge clk_in);
        foreach (tbl[i]) u_fsl_fuse_model.mem[16 + i] = tbl[i];
        rst_n_in = 1'b1;
        rc(16'h3d84, 8'h00); rc(16'h3d85, 8'h13); rc(16'h3d88, 8'h00); rc(16'h3d8b, 8'h00);
        rc(16'h3d90, 8'h12); rc(16'h3d91, 8'h06); rc(16'h3d00, 8'h00);
        // auto load with check against buffer, then setting table at fuse 0x10
        wr(16'h3d91, 8'h01); wr(16'h3d8c, 8'h00); wr(16'h3d8d, 8'h10);
        wr(16'h3d81, 8'h01);
        wait_low(16'h3d81, 0);
        chk(seen.size(), 8);
        foreach (seen[i]) chk(seen[i], {16'h3000 + 16'(i), 8'h11 * 8'(i + 1)});
        rc(16'h7010, 8'hdd); rc(16'h7014, 8'h11);
        rc(16'h3d81, 8'h30); rc(16'h3d8e, 8'h70); rc(16'h3d8f, 8'h10);
        // program two bytes through the manual range
        wr(16'h3d84, 8'h40); wr(16'h3d88, 8'h70); wr(16'h3d89, 8'h00); wr(16'h3d8a, 8'h70);
        wr(16'h3d8b, 8'h01); stream_on_in = 1'b1; wr(16'h7000, 8'h5a); wr(16'h7001, 8'ha5);
        wr(16'h3d80, 8'h01); wait_low(16'h3d80, 7); wr(16'h3d80, 8'h00);
        chk(u_fsl_fuse_model.mem[0], 8'h5a); chk(u_fsl_fuse_model.mem[1], 8'ha5);
        // inhibited programming leaves fuses alone
        wr(16'h3d84, 8'hc0); wr(16'h7000, 8'hff); wr(16'h3d80, 8'h01); wait_low(16'h3d80, 7);
        chk(u_fsl_fuse_model.mem[0], 8'h5a);
        // mid-run reset, then power-up load of a manual range checked against zero
        @(negedge clk_in); rst_n_in = 1'b0; stream_on_in = 1'b0;
        repeat (2) @(negedge clk_in); rst_n_in = 1'b1;
        rc(16'h3d88, 8'h00); rc(16'h3d81, 8'h00);
        wr(16'h3d84, 8'h40); wr(16'h3d88, 8'h70); wr(16'h3d89, 8'h11); wr(16'h3d8a, 8'h70);
        wr(16'h3d8b, 8'h13); wr(16'h3d8d, 8'h1f); wr(16'h3d85, 8'h36); wr(16'h7011, 8'ha3);
        stream_on_in = 1'b1; repeat (4) @(negedge clk_in); wait_low(16'h3d81, 7);
        chk(seen.size(), 8); rc(16'h3d81, 8'h30); rc(16'h3d8f, 8'h11);
        rc(16'h7012, 8'h30); rc(16'h7014, 8'h00);
        end_of_test;
    end
endmodule // otp_setting_loader_bist_bench
